// file: core/sse_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none

module sse_axil_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output logic [11:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic [11:0]      rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);

    logic aw_have_q;
    logic w_have_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // ----------------------------------------
    // Write channels
    // ----------------------------------------
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign wr_en         = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            wr_addr   <= 12'h000;
        end else if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            wr_addr   <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wr_data  <= 32'h00000000;
            wr_strb  <= 4'h0;
        end else if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            wr_data  <= s_axi_wdata;
            wr_strb  <= s_axi_wstrb;
        end else if (wr_en) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= sse_pkg::SSE_RESP_OKAY;
        end else if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_err ? sse_pkg::SSE_RESP_SLVERR : sse_pkg::SSE_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ----------------------------------------
    // Read channels
    // ----------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign rd_addr       = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= sse_pkg::SSE_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data;
            rresp_q  <= rd_err ? sse_pkg::SSE_RESP_SLVERR : sse_pkg::SSE_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule // sse_axil_slave

`default_nettype wire

// file: core/sse_event_regs.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

`include "sse_regs.svh"

// Summary of operation
// - Semaphore-taken flag resets to zero, reads one once the semaphore is granted.
// - Done-event publish config holds channel index and enable, both reset zero.
// - Enabled done event is signalled on its stored channel.
// - Receive-buffer-full event has its own channel and enable for publishing.
// - Semaphore-taken event has its own publish config, routed like the others.
// - Shortcut bit set: done event triggers the semaphore request task.
// - Writing one to enable-set enables that event's interrupt; zero ignored.
// - Writing one to enable-clear disables that event's interrupt; zero ignored.
// - Both enable registers read back the same shared enable state.
// - Transaction-done event raised when the granted transaction completes.
// - Request task asks for the semaphore; taken event follows the grant.
module sse_event_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        txn_done_evt,
    input  wire logic        rx_buffer_full_event,
    input  wire logic        sem_granted_evt,
    output logic             sem_request_task,
    output logic [15:0]      publish_channels,
    output logic             irq
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic hit(
        input logic [11:0] a,
        input logic [11:0] ofs
    );
        return a[11:2] == ofs[11:2];
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] pub_word(
        input logic            en,
        input sse_pkg::sse_chan_t ch
    );
        logic [31:0] r;
        r = `SSE_RST_WORD;
        r[`SSE_PUB_EN_BIT] = en;
        r[`SSE_CHAN_MSB:0] = ch;
        return r;
    endfunction

    function automatic sse_pkg::sse_chmap_t onehot(
        input sse_pkg::sse_chan_t ch
    );
        sse_pkg::sse_chmap_t r;
        r = 16'h0000;
        r[ch] = 1'b1;
        return r;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic               wr_en;
    logic [11:0]        wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;
    logic               wr_err;
    logic [11:0]        rd_addr;
    logic [31:0]        rd_data;
    logic               rd_err;
    sse_pkg::sse_evt_t  evt;
    sse_pkg::sse_evt_t  wr_flag;
    sse_pkg::sse_evt_t  wr_pub;
    logic               wr_link;
    logic               wr_set;
    logic               wr_clr;
    logic               wr_stat;
    sse_pkg::sse_evt_t  flags_q;
    sse_pkg::sse_evt_t  pub_en_q;
    sse_pkg::sse_chan_t pub_chan_q [0:2];
    logic               link_q;
    sse_pkg::sse_evt_t  ien_q;
    logic               irq_q;
    logic               req_q;
    sse_pkg::sse_chmap_t pub_d;
    sse_pkg::sse_chmap_t pub_q;
    logic [31:0]        merged [0:2];

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    sse_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    assign evt[`SSE_EVT_DONE]   = txn_done_evt;
    assign evt[`SSE_EVT_RXFULL] = rx_buffer_full_event;
    assign evt[`SSE_EVT_TAKEN]  = sem_granted_evt;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    always_comb begin
        wr_flag = 3'h0;
        wr_pub  = 3'h0;
        wr_link = 1'b0;
        wr_set  = 1'b0;
        wr_clr  = 1'b0;
        wr_stat = 1'b0;
        wr_err  = 1'b0;
        if (hit(wr_addr, `SSE_OFS_DONE_FLAG)) begin
            wr_flag[`SSE_EVT_DONE] = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_RXFULL_FLAG)) begin
            wr_flag[`SSE_EVT_RXFULL] = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_TAKEN_FLAG)) begin
            wr_flag[`SSE_EVT_TAKEN] = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_DONE_PUB)) begin
            wr_pub[`SSE_EVT_DONE] = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_RXFULL_PUB)) begin
            wr_pub[`SSE_EVT_RXFULL] = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_TAKEN_PUB)) begin
            wr_pub[`SSE_EVT_TAKEN] = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_LINK)) begin
            wr_link = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_IEN_SET)) begin
            wr_set = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_IEN_CLR)) begin
            wr_clr = wr_en;
        end else if (hit(wr_addr, `SSE_OFS_IRQ_STAT)) begin
            wr_stat = wr_en;
        end else begin
            wr_err = 1'b1;
        end
    end

    // ----------------------------------------
    // Event flags
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= `SSE_RST_EVT;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (evt[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (wr_flag[i] && wr_strb[0]) begin
                    flags_q[i] <= wr_data[0];
                end else if (wr_stat && wr_strb[0] && wr_data[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Publish configuration
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            merged[i] = merge(pub_word(pub_en_q[i], pub_chan_q[i]), wr_data, wr_strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pub_en_q <= `SSE_RST_EVT;
            for (int i = 0; i < 3; i++) begin
                pub_chan_q[i] <= `SSE_RST_CHAN;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_pub[i]) begin
                    pub_en_q[i]   <= merged[i][`SSE_PUB_EN_BIT];
                    pub_chan_q[i] <= merged[i][`SSE_CHAN_MSB:0];
                end
            end
        end
    end

    always_comb begin
        pub_d = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            if (evt[i] && pub_en_q[i]) begin
                pub_d = pub_d | onehot(pub_chan_q[i]);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pub_q <= 16'h0000;
        end else begin
            pub_q <= pub_d;
        end
    end

    assign publish_channels = pub_q;

    // ----------------------------------------
    // Shortcut
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_q <= 1'b0;
        end else if (wr_link && wr_strb[0]) begin
            link_q <= wr_data[`SSE_LINK_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
        end else begin
            req_q <= evt[`SSE_EVT_DONE] && link_q;
        end
    end

    assign sem_request_task = req_q;

    // ----------------------------------------
    // Interrupt enables
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_q <= `SSE_RST_EVT;
        end else if (wr_set && wr_strb[0]) begin
            ien_q <= ien_q | wr_data[2:0];
        end else if (wr_clr && wr_strb[0]) begin
            ien_q <= ien_q & ~wr_data[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & ien_q);
        end
    end

    assign irq = irq_q;

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb begin
        rd_data = `SSE_RST_WORD;
        rd_err  = 1'b0;
        if (hit(rd_addr, `SSE_OFS_DONE_FLAG)) begin
            rd_data[0] = flags_q[`SSE_EVT_DONE];
        end else if (hit(rd_addr, `SSE_OFS_RXFULL_FLAG)) begin
            rd_data[0] = flags_q[`SSE_EVT_RXFULL];
        end else if (hit(rd_addr, `SSE_OFS_TAKEN_FLAG)) begin
            rd_data[0] = flags_q[`SSE_EVT_TAKEN];
        end else if (hit(rd_addr, `SSE_OFS_DONE_PUB)) begin
            rd_data = pub_word(pub_en_q[0], pub_chan_q[0]);
        end else if (hit(rd_addr, `SSE_OFS_RXFULL_PUB)) begin
            rd_data = pub_word(pub_en_q[1], pub_chan_q[1]);
        end else if (hit(rd_addr, `SSE_OFS_TAKEN_PUB)) begin
            rd_data = pub_word(pub_en_q[2], pub_chan_q[2]);
        end else if (hit(rd_addr, `SSE_OFS_LINK)) begin
            rd_data[`SSE_LINK_BIT] = link_q;
        end else if (hit(rd_addr, `SSE_OFS_IEN_SET)) begin
            rd_data[2:0] = ien_q;
        end else if (hit(rd_addr, `SSE_OFS_IEN_CLR)) begin
            rd_data[2:0] = ien_q;
        end else if (hit(rd_addr, `SSE_OFS_IRQ_STAT)) begin
            rd_data[2:0] = flags_q;
        end else begin
            rd_err = 1'b1;
        end
    end

endmodule // sse_event_regs

`default_nettype wire

// file: core/sse_pkg.sv
package sse_pkg;

    typedef logic [2:0]  sse_evt_t;
    typedef logic [3:0]  sse_chan_t;
    typedef logic [15:0] sse_chmap_t;

    typedef enum logic [1:0] {
        SSE_RESP_OKAY   = 2'h0,
        SSE_RESP_SLVERR = 2'h2
    } sse_resp_e;

endpackage

// file: core/sse_regs.svh
`ifndef SSE_REGS_SVH
`define SSE_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSE_OFS_DONE_FLAG   12'h104
`define SSE_OFS_RXFULL_FLAG 12'h110
`define SSE_OFS_TAKEN_FLAG  12'h128
`define SSE_OFS_DONE_PUB    12'h184
`define SSE_OFS_RXFULL_PUB  12'h190
`define SSE_OFS_TAKEN_PUB   12'h1A8
`define SSE_OFS_LINK        12'h200
`define SSE_OFS_IEN_SET     12'h304
`define SSE_OFS_IEN_CLR     12'h308
`define SSE_OFS_IRQ_STAT    12'h30C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SSE_PUB_EN_BIT      31
`define SSE_CHAN_MSB        3
`define SSE_LINK_BIT        0
`define SSE_EVT_DONE        0
`define SSE_EVT_RXFULL      1
`define SSE_EVT_TAKEN       2
`define SSE_RST_WORD        32'h00000000
`define SSE_RST_EVT         3'h0
`define SSE_RST_CHAN        4'h0

`endif

// file: verification/sse_event_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module sse_event_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        txn_done_evt,
    input wire logic        rx_buffer_full_event,
    input wire logic        sem_granted_evt,
    input wire logic        sem_request_task,
    input wire logic [15:0] publish_channels,
    input wire logic        irq
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    logic       any_evt;
    logic [2:0] evts;
    assign evts    = {sem_granted_evt, rx_buffer_full_event, txn_done_evt};
    assign any_evt = |evts;

    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    pub_cause_a: assert property (publish_channels != 16'h0000 |-> $past(any_evt))
        else $error("publish pulse without event");
    pub_solo_a: assert property ($countones(evts) == 1 |=> $onehot0(publish_channels))
        else $error("single event published on several channels");
    req_cause_a: assert property (sem_request_task |-> $past(txn_done_evt))
        else $error("semaphore request without done event");
    req_pulse_a: assert property (sem_request_task && !txn_done_evt |=> !sem_request_task)
        else $error("semaphore request longer than one cycle");
    irq_rise_a: assert property ($rose(irq) |-> $past(any_evt, 2) || $past(s_axi_bvalid))
        else $error("interrupt rose without event or write");
    irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
        else $error("interrupt fell without write");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");

    cover property (publish_channels != 16'h0000);
    cover property ($rose(irq));
    cover property (sem_request_task);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // sse_event_monitor

bind sse_event_regs sse_event_monitor sse_event_monitor_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txn_done_evt,
    .rx_buffer_full_event, .sem_granted_evt, .sem_request_task, .publish_channels, .irq);

`default_nettype wire

// file: verification/sse_evt_peer.sv
`timescale 1ns/100ps
`default_nettype none

module sse_evt_peer (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [2:0] fire,
    input wire logic [3:0] grant_dly,
    input wire logic       sem_request_task,
    output logic           txn_done_evt,
    output logic           rx_buffer_full_event,
    output logic           sem_granted_evt
);
    // ----------------------------------------
    // Event source and semaphore arbiter
    // ----------------------------------------
    logic [3:0] wait_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txn_done_evt         <= 1'b0;
            rx_buffer_full_event <= 1'b0;
            sem_granted_evt      <= 1'b0;
            wait_q               <= 4'h0;
        end else begin
            txn_done_evt         <= fire[0];
            rx_buffer_full_event <= fire[1];
            sem_granted_evt      <= fire[2] || wait_q == 4'h1;
            if (sem_request_task) begin
                wait_q <= grant_dly;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule // sse_evt_peer

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none

`include "sse_regs.svh"

module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq, irq_prev, sem_request_task;
    logic        txn_done_evt, rx_buffer_full_event, sem_granted_evt;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] publish_channels;
    logic [2:0]  fire, s_axi_awprot, s_axi_arprot;
    logic [3:0]  grant_dly, s_axi_wstrb;
    logic [3:0]  ch [3];
    logic [31:0] exp_r[$], exp_pub[$], exp_irq[$];
    logic [1:0]  exp_rr[$], exp_b[$];
    int          miscompares, samples_checked, cyc;
    logic [11:0] pub_ofs [3] = '{`SSE_OFS_DONE_PUB, `SSE_OFS_RXFULL_PUB, `SSE_OFS_TAKEN_PUB};
    logic [11:0] reg_ofs [10] = '{`SSE_OFS_DONE_FLAG, `SSE_OFS_RXFULL_FLAG, `SSE_OFS_TAKEN_FLAG,
        `SSE_OFS_DONE_PUB, `SSE_OFS_RXFULL_PUB, `SSE_OFS_TAKEN_PUB, `SSE_OFS_LINK,
        `SSE_OFS_IEN_SET, `SSE_OFS_IEN_CLR, `SSE_OFS_IRQ_STAT};

    sse_event_regs sse_event_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .txn_done_evt, .rx_buffer_full_event, .sem_granted_evt,
        .sem_request_task, .publish_channels, .irq);

    sse_evt_peer sse_evt_peer_inst (.aclk, .aresetn, .fire, .grant_dly, .sem_request_task,
        .txn_done_evt, .rx_buffer_full_event, .sem_granted_evt);

    // ----------------------------------------
    // Clock, tasks and result watcher
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task conclude;
        if (exp_pub.size() != 0 || exp_irq.size() != 0) miscompares++;
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = sse_pkg::SSE_RESP_OKAY, input logic [3:0] s = 4'hF);
        exp_b.push_back(r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awprot  <= 3'($urandom);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = sse_pkg::SSE_RESP_OKAY);
        exp_r.push_back(d);
        exp_rr.push_back(r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arprot  <= 3'($urandom);
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic fire_evt(input logic [2:0] f, input logic [31:0] p);
        if (p != 32'h00000000) exp_pub.push_back(p);
        @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= 3'h0;
        repeat (14) @(posedge aclk);
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (s_axi_rvalid && s_axi_rready) begin
            chk("rdata", s_axi_rdata, exp_r.pop_front());
            chk("rresp", 32'(s_axi_rresp), 32'(exp_rr.pop_front()));
        end
        if (s_axi_bvalid && s_axi_bready) chk("bresp", 32'(s_axi_bresp), 32'(exp_b.pop_front()));
        if (publish_channels !== 16'h0000) chk("publish", 32'(publish_channels),
            exp_pub.size() != 0 ? exp_pub.pop_front() : 32'hXXXXXXXX);
        if (aresetn && irq !== irq_prev) chk("irq", 32'(irq),
            exp_irq.size() != 0 ? exp_irq.pop_front() : 32'hXXXXXXXX);
        irq_prev = irq;
        if (cyc == 5000) begin
            miscompares++;
            conclude;
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire, grant_dly} = 63'h0;
        irq_prev = 1'b0;
        void'($urandom(19));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (reg_ofs[i]) rd(reg_ofs[i], `SSE_RST_WORD);
        rd(12'h00C, 32'h00000000, sse_pkg::SSE_RESP_SLVERR);
        wr(12'h00C, 32'hFFFFFFFF, sse_pkg::SSE_RESP_SLVERR);
        wr(`SSE_OFS_IEN_SET, 32'h00000005);
        rd(`SSE_OFS_IEN_SET, 32'h00000005);
        rd(`SSE_OFS_IEN_CLR, 32'h00000005);
        wr(`SSE_OFS_IEN_CLR, 32'h00000001);
        wr(`SSE_OFS_IEN_SET, 32'h00000000);
        wr(`SSE_OFS_IEN_CLR, 32'h00000000);
        rd(`SSE_OFS_IEN_SET, 32'h00000004);
        wr(`SSE_OFS_IEN_CLR, 32'h00000004);
        rd(`SSE_OFS_IEN_CLR, 32'h00000000);
        wr(`SSE_OFS_IEN_SET, 32'h00000002, sse_pkg::SSE_RESP_OKAY, 4'h0);
        rd(`SSE_OFS_IEN_SET, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            ch[i] = 4'($urandom % 16);
            wr(pub_ofs[i], {1'b1, 27'h0, ch[i]});
            rd(pub_ofs[i], {1'b1, 27'h0, ch[i]});
            fire_evt(3'(1 << i), 32'(16'h1 << ch[i]));
        end
        fire_evt(3'h7, 32'((16'h1 << ch[0]) | (16'h1 << ch[1]) | (16'h1 << ch[2])));
        rd(`SSE_OFS_DONE_FLAG, 32'h00000001);
        rd(`SSE_OFS_TAKEN_FLAG, 32'h00000001);
        rd(`SSE_OFS_IRQ_STAT, 32'h00000007);
        exp_irq.push_back(32'h1);
        wr(`SSE_OFS_IEN_SET, 32'h00000002);
        exp_irq.push_back(32'h0);
        wr(`SSE_OFS_IRQ_STAT, 32'h00000002);
        rd(`SSE_OFS_RXFULL_FLAG, 32'h00000000);
        wr(`SSE_OFS_IEN_CLR, 32'h00000002);
        fire_evt(3'h2, 32'(16'h1 << ch[1]));
        rd(`SSE_OFS_IRQ_STAT, 32'h00000007);
        exp_irq.push_back(32'h1);
        wr(`SSE_OFS_IEN_SET, 32'h00000002);
        exp_irq.push_back(32'h0);
        wr(`SSE_OFS_IEN_CLR, 32'h00000002);
        wr(`SSE_OFS_IRQ_STAT, 32'h00000007);
        wr(`SSE_OFS_LINK, 32'h00000001);
        grant_dly <= 4'($urandom % 8 + 1);
        exp_pub.push_back(32'(16'h1 << ch[0]));
        fire_evt(3'h1, 32'(16'h1 << ch[2]));
        rd(`SSE_OFS_TAKEN_FLAG, 32'h00000001);
        wr(`SSE_OFS_TAKEN_FLAG, 32'h00000000);
        wr(`SSE_OFS_LINK, 32'h00000000);
        fire_evt(3'h1, 32'(16'h1 << ch[0]));
        rd(`SSE_OFS_TAKEN_FLAG, 32'h00000000);
        wr(pub_ofs[1], {28'h0, ch[1]});
        fire_evt(3'h2, 32'h00000000);
        repeat (8) @(posedge aclk);
        conclude;
    end
endmodule // testbench

`default_nettype wire
